//--- cfg_pkg.sv
package cfg_pkg;

    localparam int NUM_FN = 8;
    localparam int NUM_PF = 2;
    localparam int NUM_VF = 6;
    localparam int ADDR_W = 19;
    localparam int LOCAL_BIT = 18;
    localparam int FN_HI = 17;
    localparam int FN_LO = 10;
    localparam int REG_HI = 9;
    localparam int REG_WORDS = 32;

    localparam logic [9:0] REG_ID = 10'h000;
    localparam logic [9:0] REG_CMD = 10'h001;
    localparam logic [9:0] REG_CLASS = 10'h002;
    localparam logic [9:0] TYPE1_LAST = 10'h00F;
    localparam logic [9:0] REG_PMCSR = 10'h011;
    localparam logic [9:0] REG_DEVCTL = 10'h012;
    localparam logic [9:0] REG_LINK = 10'h014;
    localparam logic [9:0] LREG_VF_EN = 10'h000;

    localparam int CMD_IO = 0;
    localparam int CMD_MEM = 1;
    localparam int CMD_BME = 2;
    localparam int CMD_INTX = 10;
    localparam int DEVCTL_COR = 0;
    localparam int DEVCTL_NONFATAL = 1;
    localparam int DEVCTL_FATAL = 2;
    localparam int PAYLOAD_LO = 5;
    localparam int RDREQ_LO = 12;

    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] PMCSR_RST = 16'h0000;
    localparam logic [15:0] DEVCTL_RST = 16'h2000;
    localparam logic [15:0] LNKCTL_RST = 16'h0000;
    localparam logic [5:0] VF_EN_RST = 6'h00;

    localparam logic [2:0] PWR_D0_UNINIT = 3'h0;
    localparam logic [2:0] PWR_D0_ACTIVE = 3'h1;
    localparam logic [2:0] PWR_D1 = 3'h2;
    localparam logic [2:0] PWR_D3HOT = 3'h4;

    localparam logic [1:0] LP_L0 = 2'h0;
    localparam logic [1:0] LP_L0S = 2'h1;
    localparam logic [1:0] LP_L1 = 2'h2;
    localparam logic [1:0] LP_L2 = 2'h3;

    localparam logic [1:0] LS_NO_RX = 2'h0;
    localparam logic [1:0] LS_TRAIN = 2'h1;
    localparam logic [1:0] LS_DL_INIT = 2'h2;
    localparam logic [1:0] LS_UP = 2'h3;

    typedef enum logic [3:0] {
        PH_DETECT = 4'h0, PH_POLLING = 4'h1, PH_CONFIG = 4'h2,
        PH_RECOVERY = 4'h3, PH_L0 = 4'h4, PH_L0S = 4'h5,
        PH_L1 = 4'h6, PH_L2 = 4'h7, PH_OTHER = 4'h8
    } phy_phase_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HOLD = 2'b11
    } mgmt_state_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [31:0] write_data;
        logic [3:0] byte_enable;
        logic read;
    } mgmt_req_type;

    typedef struct packed {
        phy_phase_type phase;
        logic dl_init_done;
        logic [3:0] lane_width;
        logic [2:0] speed;
    } phy_stat_type;

    typedef struct packed {
        logic [NUM_FN-1:0] cor;
        logic [NUM_FN-1:0] nonfatal;
        logic [NUM_FN-1:0] fatal;
    } err_det_type;

    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
        input logic [31:0] new_w, input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] lanes;
        for (int i = 0; i < 4; i++) begin
            lanes[i*8 +: 8] = {8{be[i]}};
        end
        return (old_w & ~(lanes & mask)) | (new_w & lanes & mask);
    endfunction : be_merge

    function automatic logic [2:0] pwr_code(input logic [1:0] pm,
        input logic [1:0] decode_en);
        case (pm)
            2'b00: return (decode_en != 2'b00) ? PWR_D0_ACTIVE : PWR_D0_UNINIT;
            2'b11: return PWR_D3HOT;
            default: return PWR_D1;
        endcase
    endfunction : pwr_code

endpackage : cfg_pkg

//--- cfg_word_store.sv
`timescale 1ns/1ps
module cfg_word_store #(
    parameter int WORDS = 256,
    parameter int AW = 8
) (
    input logic mclk,
    input logic arst_n,
    input logic we,
    input logic [AW-1:0] waddr,
    input logic [31:0] wdata,
    input logic [AW-1:0] raddr,
    output logic [31:0] rdata
);

    logic [31:0] mem_ff [WORDS];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_ff[i] <= 32'h0000_0000;
            end
        end else if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    assign rdata = mem_ff[raddr];

endmodule : cfg_word_store

//--- cfg_err_pulse.sv
`timescale 1ns/1ps
module cfg_err_pulse #(
    parameter int NFN = 8
) (
    input logic mclk,
    input logic arst_n,
    input logic root_mode,
    input logic [NFN-1:0] det,
    input logic [NFN-1:0] en,
    output logic pulse
);

    logic hit;
    logic hit_ff;
    logic pulse_ff;

    // Root port looks only at its own function
    assign hit = root_mode ? (det[0] & en[0]) : |(det & en);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hit_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            hit_ff <= hit;
            pulse_ff <= hit & ~hit_ff;
        end
    end

    assign pulse = pulse_ff;

endmodule : cfg_err_pulse

//--- pcie_cfg_mgmt_and_status.sv
`timescale 1ns/1ps
// What this block does
// - Address bits 17:10 function, 9:0 register.
// - Write strobe with byte-enabled 32-bit data.
// - Read strobe returns addressed 32-bit word.
// - Done pulses exactly one cycle per access.
// - Root override writes read-only type-1 fields of function 0, except the ID word.
// - Link-down is inverse of LinkUp.
// - LinkUp by state; configuration depends on path.
// - Two-bit link progress code.
// - Width mirrors link status, valid at 11b.
// - Speed mirrors link status speed field.
// - Payload limit copies device control 7:5.
// - Read-request limit copies device control 14:12.
// - Four command enables per physical function.
// - Two status bits per virtual function.
// - Three power bits per physical function.
// - Three power bits per virtual function.
// - Two-bit link power state code.
// - Endpoint error pulses, OR over functions.
// - Root port pulses only local errors.
module pcie_cfg_mgmt_and_status #(
    parameter logic [31:0] ID_WORD = 32'h0001_0ABC // Arbitrary identity value
) (
    input logic mclk,
    input logic arst_n,
    input logic root_port_mode,
    input cfg_pkg::mgmt_req_type mgmt_req,
    input logic type1_readonly_override,
    input cfg_pkg::phy_stat_type phy_stat,
    input cfg_pkg::err_det_type err_det,
    output logic [31:0] mgmt_read_data,
    output logic mgmt_done,
    output logic phy_link_down,
    output logic [1:0] phy_link_status,
    output logic [3:0] negotiated_width,
    output logic [2:0] current_speed,
    output logic [2:0] max_payload,
    output logic [2:0] max_read_req,
    output logic [7:0] function_status,
    output logic [11:0] virtual_fn_enables,
    output logic [5:0] function_power_state,
    output logic [17:0] virtual_fn_device_power_state,
    output logic [1:0] link_power_state,
    output logic err_cor_out,
    output logic err_nonfatal_out,
    output logic err_fatal_out
);
    import cfg_pkg::*;

    localparam int STORE_AW = $clog2(NUM_FN * REG_WORDS);

    mgmt_state_type state_ff;
    logic op_write_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] be_ff;
    logic ovr_ff;
    logic done_ff;
    logic [31:0] read_data_ff;

    logic [15:0] cmd_ff [NUM_FN];
    logic [15:0] pmcsr_ff [NUM_FN];
    logic [15:0] devctl_ff [NUM_FN];
    logic [15:0] lnkctl_ff [NUM_FN];
    logic [NUM_VF-1:0] vf_en_ff;

    logic via_poll_ff;
    logic link_down_ff;
    logic [1:0] link_status_ff;
    logic [3:0] width_ff;
    logic [2:0] speed_ff;
    logic [2:0] payload_ff;
    logic [2:0] rdreq_ff;
    logic [7:0] fn_status_ff;
    logic [11:0] vf_status_ff;
    logic [5:0] pf_power_ff;
    logic [17:0] vf_power_ff;
    logic [1:0] link_power_ff;

    logic [7:0] fn_sel;
    logic [9:0] reg_sel;
    logic [2:0] fn_idx;
    logic is_local;
    logic fn_ok;
    logic shadow_word;
    logic store_ok;
    logic [STORE_AW-1:0] store_idx;
    logic [31:0] store_rdata;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic wr_go;
    logic link_up;
    logic [15:0] lnk_stat;
    logic [NUM_FN-1:0] en_cor;
    logic [NUM_FN-1:0] en_nonfatal;
    logic [NUM_FN-1:0] en_fatal;

    // Request sequencing
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (mgmt_req.read || mgmt_req.write) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_ff <= ST_HOLD;
                end
                ST_HOLD: begin
                    // Wait for strobes to drop so a held strobe is not retaken
                    if (!mgmt_req.read && !mgmt_req.write) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            op_write_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            be_ff <= 4'h0;
            ovr_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && (mgmt_req.read || mgmt_req.write)) begin
            op_write_ff <= mgmt_req.write;
            addr_ff <= mgmt_req.addr;
            wdata_ff <= mgmt_req.write_data;
            be_ff <= mgmt_req.byte_enable;
            ovr_ff <= type1_readonly_override;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == ST_RUN);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            read_data_ff <= 32'h0000_0000;
        end else if (state_ff == ST_RUN && !op_write_ff) begin
            read_data_ff <= rd_word;
        end
    end

    // Address decode
    always_comb begin
        fn_sel = addr_ff[FN_HI:FN_LO];
        reg_sel = addr_ff[REG_HI:0];
        fn_idx = fn_sel[2:0];
        is_local = addr_ff[LOCAL_BIT];
        fn_ok = !is_local && (fn_sel < 8'(NUM_FN));
        shadow_word = (reg_sel == REG_ID) || (reg_sel == REG_CMD)
            || (reg_sel == REG_PMCSR) || (reg_sel == REG_DEVCTL)
            || (reg_sel == REG_LINK);
        store_ok = fn_ok && !shadow_word && (reg_sel < 10'(REG_WORDS));
        store_idx = {fn_idx, reg_sel[4:0]};
        wr_go = (state_ff == ST_RUN) && op_write_ff;
    end

    assign lnk_stat = {8'h00, width_ff, 1'b0, speed_ff};

    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_local) begin
            if (reg_sel == LREG_VF_EN) begin
                rd_word = {26'h0, vf_en_ff};
            end
        end else if (fn_ok) begin
            case (reg_sel)
                REG_ID: rd_word = ID_WORD;
                REG_CMD: rd_word = {16'h0000, cmd_ff[fn_idx]};
                REG_PMCSR: rd_word = {16'h0000, pmcsr_ff[fn_idx]};
                REG_DEVCTL: rd_word = {16'h0000, devctl_ff[fn_idx]};
                REG_LINK: rd_word = {lnk_stat, lnkctl_ff[fn_idx]};
                default: begin
                    if (store_ok) begin
                        rd_word = store_rdata;
                    end
                end
            endcase
        end
    end

    // Writable bits of the addressed word
    always_comb begin
        case (reg_sel)
            REG_ID, REG_CLASS: wmask = 32'h0000_0000;
            REG_PMCSR: wmask = 32'h0000_0003;
            REG_DEVCTL, REG_LINK: wmask = 32'h0000_FFFF;
            default: wmask = 32'hFFFF_FFFF;
        endcase
        if (is_local) begin
            wmask = 32'h0000_003F;
        end else if (root_port_mode && ovr_ff && fn_idx == 3'h0
            && fn_sel == 8'h00 && reg_sel <= TYPE1_LAST && reg_sel != REG_ID) begin
            wmask = 32'hFFFF_FFFF;
        end
        merged = be_merge(rd_word, wdata_ff, be_ff, wmask);
    end

    cfg_word_store #(
        .WORDS(NUM_FN * REG_WORDS),
        .AW(STORE_AW)
    ) u_store (
        .mclk(mclk),
        .arst_n(arst_n),
        .we(wr_go && store_ok),
        .waddr(store_idx),
        .wdata(merged),
        .raddr(store_idx),
        .rdata(store_rdata)
    );

    // Shadowed configuration words that drive status
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_FN; i++) begin
                cmd_ff[i] <= CMD_RST;
                pmcsr_ff[i] <= PMCSR_RST;
                devctl_ff[i] <= DEVCTL_RST;
                lnkctl_ff[i] <= LNKCTL_RST;
            end
        end else if (wr_go && fn_ok) begin
            case (reg_sel)
                REG_CMD: cmd_ff[fn_idx] <= merged[15:0];
                REG_PMCSR: pmcsr_ff[fn_idx] <= merged[15:0];
                REG_DEVCTL: devctl_ff[fn_idx] <= merged[15:0];
                REG_LINK: lnkctl_ff[fn_idx] <= merged[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vf_en_ff <= VF_EN_RST;
        end else if (wr_go && is_local && reg_sel == LREG_VF_EN) begin
            vf_en_ff <= merged[NUM_VF-1:0];
        end
    end

    // Link state tracking
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            via_poll_ff <= 1'b1;
        end else begin
            case (phy_stat.phase)
                PH_DETECT, PH_POLLING: via_poll_ff <= 1'b1;
                PH_RECOVERY, PH_L0, PH_L0S, PH_L1, PH_L2: via_poll_ff <= 1'b0;
                default: via_poll_ff <= via_poll_ff;
            endcase
        end
    end

    always_comb begin
        case (phy_stat.phase)
            PH_RECOVERY, PH_L0, PH_L0S, PH_L1, PH_L2: link_up = 1'b1;
            PH_CONFIG: link_up = !via_poll_ff;
            default: link_up = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link_down_ff <= 1'b1;
            link_status_ff <= LS_NO_RX;
        end else begin
            link_down_ff <= !link_up;
            if (phy_stat.phase == PH_DETECT) begin
                link_status_ff <= LS_NO_RX;
            end else if (!link_up) begin
                link_status_ff <= LS_TRAIN;
            end else if (!phy_stat.dl_init_done) begin
                link_status_ff <= LS_DL_INIT;
            end else begin
                link_status_ff <= LS_UP;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            width_ff <= 4'h0;
            speed_ff <= 3'h0;
        end else begin
            width_ff <= phy_stat.lane_width;
            speed_ff <= phy_stat.speed;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link_power_ff <= LP_L0;
        end else begin
            case (phy_stat.phase)
                PH_L0S: link_power_ff <= LP_L0S;
                PH_L1: link_power_ff <= LP_L1;
                PH_L2: link_power_ff <= LP_L2;
                default: link_power_ff <= LP_L0;
            endcase
        end
    end

    // Limits follow function 0, which owns the link
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            payload_ff <= DEVCTL_RST[PAYLOAD_LO +: 3];
            rdreq_ff <= DEVCTL_RST[RDREQ_LO +: 3];
        end else begin
            payload_ff <= devctl_ff[0][PAYLOAD_LO +: 3];
            rdreq_ff <= devctl_ff[0][RDREQ_LO +: 3];
        end
    end

    // Per-function enables and power states
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fn_status_ff <= 8'h00;
            pf_power_ff <= 6'h00;
        end else begin
            for (int i = 0; i < NUM_PF; i++) begin
                fn_status_ff[i*4 +: 4] <= {cmd_ff[i][CMD_INTX], cmd_ff[i][CMD_BME],
                    cmd_ff[i][CMD_MEM], cmd_ff[i][CMD_IO]};
                pf_power_ff[i*3 +: 3] <= pwr_code(pmcsr_ff[i][1:0],
                    cmd_ff[i][1:0]);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vf_status_ff <= 12'h000;
            vf_power_ff <= 18'h00000;
        end else begin
            for (int v = 0; v < NUM_VF; v++) begin
                vf_status_ff[v*2 +: 2] <= {cmd_ff[NUM_PF+v][CMD_BME], vf_en_ff[v]};
                vf_power_ff[v*3 +: 3] <= pwr_code(pmcsr_ff[NUM_PF+v][1:0],
                    cmd_ff[NUM_PF+v][1:0]);
            end
        end
    end

    // Error reporting enables per function
    always_comb begin
        for (int i = 0; i < NUM_FN; i++) begin
            en_cor[i] = devctl_ff[i][DEVCTL_COR];
            en_nonfatal[i] = devctl_ff[i][DEVCTL_NONFATAL];
            en_fatal[i] = devctl_ff[i][DEVCTL_FATAL];
        end
    end

    // Only locally detected events arrive here; remote messages go elsewhere
    cfg_err_pulse #(.NFN(NUM_FN)) u_err_cor (
        .mclk(mclk),
        .arst_n(arst_n),
        .root_mode(root_port_mode),
        .det(err_det.cor),
        .en(en_cor),
        .pulse(err_cor_out)
    );

    cfg_err_pulse #(.NFN(NUM_FN)) u_err_nonfatal (
        .mclk(mclk),
        .arst_n(arst_n),
        .root_mode(root_port_mode),
        .det(err_det.nonfatal),
        .en(en_nonfatal),
        .pulse(err_nonfatal_out)
    );

    cfg_err_pulse #(.NFN(NUM_FN)) u_err_fatal (
        .mclk(mclk),
        .arst_n(arst_n),
        .root_mode(root_port_mode),
        .det(err_det.fatal),
        .en(en_fatal),
        .pulse(err_fatal_out)
    );

    // All outputs from flops; reset sets link-down high, read-request limit to 2, the rest to zero
    assign mgmt_read_data = read_data_ff;
    assign mgmt_done = done_ff;
    assign phy_link_down = link_down_ff;
    assign phy_link_status = link_status_ff;
    assign negotiated_width = width_ff;
    assign current_speed = speed_ff;
    assign max_payload = payload_ff;
    assign max_read_req = rdreq_ff;
    assign function_status = fn_status_ff;
    assign virtual_fn_enables = vf_status_ff;
    assign function_power_state = pf_power_ff;
    assign virtual_fn_device_power_state = vf_power_ff;
    assign link_power_state = link_power_ff;

endmodule : pcie_cfg_mgmt_and_status

//--- pcie_cfg_mgmt_and_status_checker.sv
`timescale 1ns/1ps
module cfg_mgmt_checker (
    input logic mclk,
    input logic arst_n,
    input logic root_port_mode,
    input cfg_pkg::mgmt_req_type mgmt_req,
    input cfg_pkg::phy_stat_type phy_stat,
    input cfg_pkg::err_det_type err_det,
    input logic [31:0] mgmt_read_data,
    input logic mgmt_done,
    input logic phy_link_down,
    input logic [1:0] phy_link_status,
    input logic [3:0] negotiated_width,
    input logic [2:0] current_speed,
    input logic [1:0] link_power_state,
    input logic err_fatal_out
);
    import cfg_pkg::*;
    logic [1:0] up_ff;
    logic strobe;
    assign strobe = mgmt_req.read | mgmt_req.write;
    // Status checks skip the first edges after reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            up_ff <= 2'h0;
        end else if (up_ff != 2'h3) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_req_rise;
        $rose(strobe);
    endsequence
    sequence s_link_steady;
        (up_ff[1] && phy_stat.dl_init_done && $stable(phy_stat))[*3];
    endsequence
    a_done_single: assert property (mgmt_done |=> !mgmt_done)
        else $error("done too long");
    a_done_latency: assert property (s_req_rise |-> ##[2:4] mgmt_done)
        else $error("done late");
    a_done_cause: assert property (mgmt_done |-> $past(strobe, 2))
        else $error("done without a request");
    a_rdata_stands: assert property (!mgmt_done |-> $stable(mgmt_read_data))
        else $error("read data moved");
    a_write_keeps_rdata: assert property (
        mgmt_done && $past(mgmt_req.write, 2) |-> $stable(mgmt_read_data))
        else $error("write changed read data");
    a_link_up_map: assert property (
        up_ff[1] && phy_stat.phase inside {PH_RECOVERY, PH_L0, PH_L0S, PH_L1, PH_L2}
        |=> !phy_link_down) else $error("link down while up");
    a_link_down_map: assert property (
        up_ff[1] && phy_stat.phase inside {PH_DETECT, PH_POLLING} |=> phy_link_down)
        else $error("link up while training");
    a_status_up: assert property (
        up_ff[1] && phy_stat.phase == PH_L0 && phy_stat.dl_init_done |=> phy_link_status == LS_UP)
        else $error("link status not up");
    a_width_mirror: assert property (
        s_link_steady |=> negotiated_width == $past(phy_stat.lane_width)
        && current_speed == $past(phy_stat.speed)) else $error("width or speed not mirrored");
    a_lp_state: assert property (
        (up_ff[1] && phy_stat.phase == PH_L1)[*2] |=> link_power_state == LP_L1)
        else $error("link power not L1");
    a_err_one_cycle: assert property (err_fatal_out |=> !err_fatal_out)
        else $error("error pulse too long");
    a_err_root_local: assert property (
        (root_port_mode && !err_det.fatal[0])[*2] |=> !err_fatal_out)
        else $error("root error pulse without local cause");
endmodule : cfg_mgmt_checker
bind pcie_cfg_mgmt_and_status cfg_mgmt_checker i_chk (.*);

//--- cfg_client_model.sv
`timescale 1ns/1ps
module cfg_client_model (
    input logic mclk,
    input logic mgmt_done,
    input logic [31:0] mgmt_read_data,
    output cfg_pkg::mgmt_req_type mgmt_req,
    output logic type1_readonly_override
);
    import cfg_pkg::*;
    initial begin
        mgmt_req = '0;
        type1_readonly_override = 1'b0;
    end
    task automatic access(input logic wr, input logic [18:0] a, input logic [31:0] d,
        input logic [3:0] be, input logic ovr, output logic [31:0] q, output logic ok);
        int n = 0;
        @(negedge mclk);
        mgmt_req = '{addr: a, write: wr, write_data: d, byte_enable: be, read: !wr};
        type1_readonly_override = ovr;
        do begin
            @(negedge mclk);
            n++;
        end while (mgmt_done !== 1'b1 && n < 16);
        ok = mgmt_done;
        q = mgmt_read_data;
        // Drop strobes; released lines show the inverse
        mgmt_req = '{addr: ~a, write: 1'b0, write_data: ~d, byte_enable: ~be, read: 1'b0};
        type1_readonly_override = !ovr;
        @(negedge mclk);
    endtask : access
endmodule : cfg_client_model

//--- pcie_cfg_mgmt_and_status_tb.sv
`timescale 1ns/1ps
module pcie_cfg_mgmt_and_status_tb;
    import cfg_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h0000_5A5A; // Arbitrary identity value
    logic mclk, arst_n, root_port_mode, type1_readonly_override, mgmt_done, phy_link_down;
    logic err_cor_out, err_nonfatal_out, err_fatal_out;
    mgmt_req_type mgmt_req;
    phy_stat_type phy_stat;
    err_det_type err_det;
    logic [31:0] mgmt_read_data;
    logic [1:0] phy_link_status, link_power_state;
    logic [3:0] negotiated_width;
    logic [2:0] current_speed, max_payload, max_read_req;
    logic [7:0] function_status;
    logic [11:0] virtual_fn_enables;
    logic [5:0] function_power_state;
    logic [17:0] virtual_fn_device_power_state;
    int err_total = 0;
    int samples_checked = 0;
    pcie_cfg_mgmt_and_status #(.ID_WORD(ID_VAL)) i_dut (.*);
    cfg_client_model i_client (.*);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [18:0] fa(input logic [7:0] f, input logic [9:0] r);
        return {1'b0, f, r};
    endfunction : fa
    task automatic wr(input logic [18:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF,
        input logic ovr = 1'b0);
        logic [31:0] q;
        logic ok;
        i_client.access(1'b1, a, d, be, ovr, q, ok);
        chk(ok, 1'b1);
    endtask : wr
    task automatic rd(input logic [18:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic ok;
        i_client.access(1'b0, a, 32'h0, 4'h0, 1'b0, q, ok);
        chk(ok, 1'b1);
        chk(q, exp);
    endtask : rd
    task automatic do_reset(input logic root);
        arst_n = 1'b0;
        root_port_mode = root;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        chk({phy_link_down, max_read_req, mgmt_done, function_status}, 13'h1400);
    endtask : do_reset
    task automatic t_bytes();
        wr(fa(8'h01, 10'h005), 32'h1122_3344);
        wr(fa(8'h00, 10'h005), 32'h5566_7788);
        wr(fa(8'h01, 10'h005), 32'hAABB_CCDD, 4'h5);
        rd(fa(8'h01, 10'h005), 32'h11BB_33DD);
        rd(fa(8'h00, 10'h005), 32'h5566_7788);
        rd(fa(8'h08, 10'h005), 32'h0000_0000);
        wr(fa(8'h00, REG_ID), 32'hFFFF_FFFF);
        rd(fa(8'h00, REG_ID), ID_VAL);
    endtask : t_bytes
    task automatic t_fn_status();
        wr(fa(8'h00, REG_CMD), 32'h0000_0407);
        wr(fa(8'h01, REG_CMD), 32'h0000_0002);
        wr(fa(8'h02, REG_CMD), 32'h0000_0006);
        wr(fa(8'h01, REG_PMCSR), 32'h0000_0003);
        wr({1'b1, 8'h00, LREG_VF_EN}, 32'h0000_0005);
        repeat (3) @(negedge mclk);
        chk(function_status, 8'h2F);
        chk(virtual_fn_enables, 12'h013);
        chk(function_power_state, 6'h21);
        chk(virtual_fn_device_power_state, 18'h00001);
    endtask : t_fn_status
    task automatic t_limits();
        for (int c = 0; c < 6; c++) begin
            wr(fa(8'h00, REG_DEVCTL), {17'h0, c[2:0], 4'h0, c[2:0], 5'h00});
            repeat (2) @(negedge mclk);
            chk({max_read_req, max_payload}, {c[2:0], c[2:0]});
        end
    endtask : t_limits
    task automatic t_phy();
        phy_phase_type ph[9] = '{PH_DETECT, PH_POLLING, PH_CONFIG, PH_L0, PH_L0S, PH_L1,
            PH_L2, PH_RECOVERY, PH_CONFIG};
        logic [4:0] ex[9] = '{5'h10, 5'h14, 5'h14, 5'h08, 5'h0D, 5'h0E, 5'h0F, 5'h0C, 5'h0C};
        logic [2:0] spd[3] = '{3'h1, 3'h2, 3'h4};
        for (int i = 0; i < 9; i++) begin
            phy_stat = '{phase: ph[i], dl_init_done: (i > 3), lane_width: 4'h8, speed: 3'h4};
            repeat (4) @(negedge mclk);
            chk({phy_link_down, phy_link_status, link_power_state}, ex[i]);
        end
        for (int i = 0; i < 3; i++) begin
            phy_stat.speed = spd[i];
            repeat (4) @(negedge mclk);
            chk({negotiated_width, current_speed}, {4'h8, spd[i]});
        end
        rd(fa(8'h00, REG_LINK), 32'h0084_0000);
    endtask : t_phy
    task automatic err_try(input err_det_type d, input logic [5:0] exp);
        int a = 0, b = 0, c = 0;
        err_det = d;
        repeat (6) begin
            @(negedge mclk);
            a += err_cor_out;
            b += err_nonfatal_out;
            c += err_fatal_out;
        end
        err_det = '0;
        repeat (3) @(negedge mclk);
        chk({a[1:0], b[1:0], c[1:0]}, exp);
    endtask : err_try
    task automatic t_err_endpoint();
        wr(fa(8'h01, REG_DEVCTL), 32'h0000_2001);
        wr(fa(8'h02, REG_DEVCTL), 32'h0000_0002);
        err_try('{cor: 8'h02, nonfatal: 8'h04, fatal: 8'h01}, 6'b010100);
    endtask : t_err_endpoint
    task automatic t_root();
        wr(fa(8'h00, REG_DEVCTL), 32'h0000_0007);
        wr(fa(8'h01, REG_DEVCTL), 32'h0000_0007);
        err_try('{cor: 8'h02, nonfatal: 8'h00, fatal: 8'h03}, 6'b000001);
        wr(fa(8'h00, REG_CLASS), 32'hCAFE_0001, 4'hF, 1'b1);
        rd(fa(8'h00, REG_CLASS), 32'hCAFE_0001);
        wr(fa(8'h00, REG_CLASS), 32'h1234_5678);
        rd(fa(8'h00, REG_CLASS), 32'hCAFE_0001);
    endtask : t_root
    initial begin
        phy_stat = '0;
        err_det = '0;
        do_reset(1'b0);
        t_bytes();
        t_fn_status();
        t_limits();
        t_phy();
        t_err_endpoint();
        do_reset(1'b1);
        t_root();
        conclude();
    end
    initial begin
        #200us;
        err_total++;
        conclude();
    end
endmodule : pcie_cfg_mgmt_and_status_tb
